// >>> core/tdcoh_pkg.sv
// Package: constants, opcodes, states and state record of the opcode handler
package tdcoh_pkg;
  localparam int          DW            = 16;
  localparam int          AW            = 4;
  localparam int          MAX_CH        = 128;
  localparam int          WW            = 32;

  // Register byte offsets
  localparam logic [3:0]  OFS_CMD       = 4'h0;
  localparam logic [3:0]  OFS_STATUS    = 4'h4;
  localparam logic [3:0]  OFS_IRQ_STAT  = 4'h8;
  localparam logic [3:0]  OFS_IRQ_MASK  = 4'hc;

  // Opcode identifiers (upper byte)
  localparam logic [7:0]  OP_DT_RD      = 8'h29;
  localparam logic [7:0]  OP_HT_EN      = 8'h30;
  localparam logic [7:0]  OP_HT_DIS     = 8'h31;
  localparam logic [7:0]  OP_HT_RD      = 8'h32;
  localparam logic [7:0]  OP_HL_SET     = 8'h33;
  localparam logic [7:0]  OP_HL_RD      = 8'h34;
  localparam logic [7:0]  OP_EM_EN      = 8'h35;
  localparam logic [7:0]  OP_EM_DIS     = 8'h36;
  localparam logic [7:0]  OP_BP_EN      = 8'h37;
  localparam logic [7:0]  OP_BP_DIS     = 8'h38;
  localparam logic [7:0]  OP_ET_SET     = 8'h39;
  localparam logic [7:0]  OP_ET_RD      = 8'h3a;
  localparam logic [7:0]  OP_BS_SET     = 8'h3b;
  localparam logic [7:0]  OP_BS_RD      = 8'h3c;
  localparam logic [7:0]  OP_CH_EN      = 8'h40;
  localparam logic [7:0]  OP_CH_DIS     = 8'h41;

  // Reset values
  localparam logic [1:0]  DT_RST        = 2'h0;
  localparam logic [3:0]  HL_NOLIMIT    = 4'h9;
  localparam logic [2:0]  BS_RST        = 3'h7;
  localparam logic [10:0] ET_RST        = 11'h000;

  // Readout word tags and error flags
  localparam logic [3:0]  TAG_HDR       = 4'h1;
  localparam logic [3:0]  TAG_ERR       = 4'h2;
  localparam logic [3:0]  TAG_TRL       = 4'h3;
  localparam logic [15:0] FLG_SIZE      = 16'h1000;
  localparam logic [15:0] FLG_GLOBAL    = 16'h0800;

  // Interrupt bit positions and width
  localparam int          IRQ_SIZE      = 0;
  localparam int          IRQ_GERR      = 1;
  localparam int          IRQ_BADOP     = 2;
  localparam int          IRQ_W         = 3;

  typedef enum logic [1:0] {
    TDCOH_IDLE       = 2'b00,
    TDCOH_WAIT_PARAM = 2'b01,
    TDCOH_WAIT_READ  = 2'b10
  } tdcoh_fsm_e;

  typedef struct packed {
    tdcoh_fsm_e          st;
    logic                busy;
    logic [7:0]          pend_op;
    logic [DW-1:0]       rd_word;
    logic                ht_en;
    logic [3:0]          hit_lim;
    logic                err_mark;
    logic                bypass;
    logic [10:0]         err_type;
    logic [2:0]          buf_size;
    logic [MAX_CH-1:0]   chan_en;
    logic [DW-1:0]       rdata;
    logic [IRQ_W-1:0]    irq_stat;
    logic [IRQ_W-1:0]    irq_mask;
    logic                irq;
    logic                gerr;
    logic                in_evt;
    logic [8:0]          hit_cnt;
    logic                ovf;
    logic                gerr_seen;
    logic                pend_err;
    logic                pend_trl;
    logic                out_valid;
    logic [WW-1:0]       out_word;
  } tdcoh_state_s;
endpackage

// >>> core/tdcoh_top.sv
// Opcode interpreter for the digitizer readout settings with event composer
`timescale 1ns/1ps
module tdcoh_top
  import tdcoh_pkg::*;
#(
  parameter int NUM_CH = 128
) (
  // Clock, reset, enable
  input  wire logic                       clk_sys,
  input  wire logic                       arst_n,
  input  wire logic                       ce,
  // Register port
  input  wire logic [tdcoh_pkg::AW-1:0]   reg_addr,
  input  wire logic [tdcoh_pkg::DW-1:0]   reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [tdcoh_pkg::DW-1:0]   reg_rdata,
  output logic                            irq,
  // Settings towards the digitizer units
  output logic                            busy,
  output logic      [2:0]                 buf_size_code,
  output logic      [tdcoh_pkg::MAX_CH-1:0] chan_en,
  output logic                            global_err,
  // Error sources and acquisition mode
  input  wire logic [10:0]                int_err,
  input  wire logic                       trig_match,
  // Event input
  input  wire logic                       ev_start,
  input  wire logic                       ev_end,
  input  wire logic                       hit_valid,
  input  wire logic [tdcoh_pkg::WW-1:0]   hit_word,
  // Readout stream
  output logic                            out_valid,
  output logic      [tdcoh_pkg::WW-1:0]   out_word
);
  import tdcoh_pkg::*;

  tdcoh_state_s q;
  tdcoh_state_s d;

  logic [7:0]  op_id;
  logic [7:0]  op_idx;
  logic [8:0]  lim_val;
  logic        no_lim;
  logic        cmd_wr;
  logic        cmd_rd;
  logic [IRQ_W-1:0] ev_set;

  assign op_id  = reg_wdata[15:8];
  assign op_idx = reg_wdata[7:0];
  assign cmd_wr = reg_wr && (reg_addr == OFS_CMD);
  assign cmd_rd = reg_rd && (reg_addr == OFS_CMD);

  // Hit limit code to count
  always_comb
  begin
    no_lim  = (q.hit_lim > 4'h8);
    lim_val = 9'h000;
    if (q.hit_lim != 4'h0 && !no_lim)
    begin
      lim_val = 9'h001 << (q.hit_lim - 4'h1);
    end
  end

  always_comb
  begin
    d      = q;
    ev_set = '0;
    d.rdata = '0;
    d.out_valid = 1'b0;
    d.gerr = |(int_err & q.err_type);

    // Command controller
    case (q.st)
      TDCOH_IDLE:
      begin
        if (cmd_wr)
        begin
          d.pend_op = op_id;
          case (op_id)
            OP_DT_RD:
            begin
              d.rd_word = {14'h0000, DT_RST};
              d.st      = TDCOH_WAIT_READ;
            end
            OP_HT_EN:  d.ht_en = 1'b1;
            OP_HT_DIS: d.ht_en = 1'b0;
            OP_HT_RD:
            begin
              d.rd_word = {15'h0000, q.ht_en};
              d.st      = TDCOH_WAIT_READ;
            end
            OP_HL_RD:
            begin
              d.rd_word = {12'h000, q.hit_lim};
              d.st      = TDCOH_WAIT_READ;
            end
            OP_EM_EN:  d.err_mark = 1'b1;
            OP_EM_DIS: d.err_mark = 1'b0;
            OP_BP_EN:  d.bypass = 1'b1;
            OP_BP_DIS: d.bypass = 1'b0;
            OP_ET_RD:
            begin
              d.rd_word = {5'h00, q.err_type};
              d.st      = TDCOH_WAIT_READ;
            end
            OP_BS_RD:
            begin
              d.rd_word = {13'h0000, q.buf_size};
              d.st      = TDCOH_WAIT_READ;
            end
            OP_HL_SET, OP_ET_SET, OP_BS_SET:
            begin
              d.st = TDCOH_WAIT_PARAM;
            end
            OP_CH_EN:
            begin
              if (32'(op_idx) < NUM_CH)
              begin
                d.chan_en[op_idx[6:0]] = 1'b1;
              end
            end
            OP_CH_DIS:
            begin
              if (32'(op_idx) < NUM_CH)
              begin
                d.chan_en[op_idx[6:0]] = 1'b0;
              end
            end
            default: ev_set[IRQ_BADOP] = 1'b1;
          endcase
        end
      end
      TDCOH_WAIT_PARAM:
      begin
        // Only a write to the command register releases the wait
        if (cmd_wr)
        begin
          case (q.pend_op)
            OP_HL_SET: d.hit_lim  = reg_wdata[3:0];
            OP_ET_SET: d.err_type = reg_wdata[10:0];
            OP_BS_SET: d.buf_size = reg_wdata[2:0];
            default:   d.hit_lim  = q.hit_lim;
          endcase
          d.st = TDCOH_IDLE;
        end
      end
      TDCOH_WAIT_READ:
      begin
        if (cmd_rd)
        begin
          d.rdata = q.rd_word;
          d.st    = TDCOH_IDLE;
        end
        else if (cmd_wr)
        begin
          ev_set[IRQ_BADOP] = 1'b1;
        end
      end
      default: d.st = TDCOH_IDLE;
    endcase

    // Register reads other than the pending answer
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_STATUS:   d.rdata = {14'h0000, q.st};
        OFS_IRQ_STAT: d.rdata = {13'h0000, q.irq_stat};
        OFS_IRQ_MASK: d.rdata = {13'h0000, q.irq_mask};
        default:      d.rdata = d.rdata;
      endcase
    end
    if (reg_wr && reg_addr == OFS_IRQ_MASK)
    begin
      d.irq_mask = reg_wdata[IRQ_W-1:0];
    end

    // Event composer
    if (q.pend_err)
    begin
      d.out_valid = 1'b1;
      d.out_word  = {TAG_ERR, 12'h000,
                     (q.ovf ? FLG_SIZE : 16'h0000) |
                     ((q.gerr_seen && q.err_mark) ? FLG_GLOBAL : 16'h0000)};
      d.pend_err  = 1'b0;
    end
    else if (q.pend_trl)
    begin
      d.out_valid = 1'b1;
      d.out_word  = {TAG_TRL, 19'h00000, q.hit_cnt};
      d.pend_trl  = 1'b0;
    end
    else if (ev_start)
    begin
      d.in_evt    = 1'b1;
      d.hit_cnt   = 9'h000;
      d.ovf       = 1'b0;
      d.gerr_seen = 1'b0;
      if (trig_match && q.ht_en)
      begin
        d.out_valid = 1'b1;
        d.out_word  = {TAG_HDR, 28'h0000000};
      end
    end
    else if (q.in_evt)
    begin
      if (q.gerr)
      begin
        d.gerr_seen = 1'b1;
      end
      if (hit_valid && !(trig_match && q.bypass && (q.gerr || q.gerr_seen)))
      begin
        if (!trig_match || no_lim || q.hit_cnt < lim_val)
        begin
          d.out_valid = 1'b1;
          d.out_word  = hit_word;
          if (q.hit_cnt != 9'h1ff)
          begin
            d.hit_cnt = q.hit_cnt + 9'h001;
          end
        end
        else
        begin
          d.ovf = 1'b1;
        end
      end
      if (ev_end)
      begin
        d.in_evt = 1'b0;
        if (trig_match)
        begin
          d.pend_err = d.ovf || ((d.gerr_seen) && q.err_mark);
          d.pend_trl = q.ht_en;
          ev_set[IRQ_SIZE] = d.ovf;
        end
      end
    end

    if (q.gerr && !d.gerr)
    begin
      ev_set[IRQ_GERR] = 1'b0;
    end
    ev_set[IRQ_GERR] = d.gerr && !q.gerr;

    // Sticky status: set wins over write-one-clear
    if (reg_wr && reg_addr == OFS_IRQ_STAT)
    begin
      d.irq_stat = q.irq_stat & ~reg_wdata[IRQ_W-1:0];
    end
    d.irq_stat = d.irq_stat | ev_set;
    d.irq      = |(d.irq_stat & d.irq_mask);
    // Wait flag kept in its own flop so the output needs no decode
    d.busy     = (d.st != TDCOH_IDLE);
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q          <= '0;
      q.st       <= TDCOH_IDLE;
      q.hit_lim  <= HL_NOLIMIT;
      q.err_mark <= 1'b1;
      q.err_type <= ET_RST;
      q.buf_size <= BS_RST;
      q.chan_en  <= '1;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  assign reg_rdata     = q.rdata;
  assign irq           = q.irq;
  assign busy          = q.busy;
  assign buf_size_code = q.buf_size;
  assign chan_en       = q.chan_en;
  assign global_err    = q.gerr;
  assign out_valid     = q.out_valid;
  assign out_word      = q.out_word;
endmodule

// >>> verification/tdc_readout_opcode_handler_test.sv
// Testbench of the opcode handler: settings, interrupts, channels, events
`timescale 1ns/1ps
module tdc_readout_opcode_handler_test;
  import tdcoh_pkg::*;
  logic              clk_sys = 1'b0, arst_n = 1'b0, ce = 1'b1, trig_match = 1'b1;
  logic              ev_start = 1'b0, ev_end = 1'b0, hit_valid = 1'b0;
  logic [10:0]       int_err = '0;
  logic [WW-1:0]     hit_word = '0, out_word;
  logic [AW-1:0]     reg_addr;
  logic [DW-1:0]     reg_wdata, reg_rdata, v;
  logic              reg_wr, reg_rd, irq, busy, global_err, out_valid;
  logic [2:0]        buf_size_code;
  logic [MAX_CH-1:0] chan_en;
  logic [WW-1:0]     q[$];
  int                errors = 0, checks = 0, cyc = 0;

  tdcoh_top #(.NUM_CH(128)) i_dut (.clk_sys, .arst_n, .ce, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq, .busy, .buf_size_code, .chan_en, .global_err, .int_err,
    .trig_match, .ev_start, .ev_end, .hit_valid, .hit_word, .out_valid, .out_word);
  tdcoh_host i_host (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (out_valid === 1'b1)
      q.push_back(out_word);
    if (cyc == 5000)
    begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [WW-1:0] seen, input logic [WW-1:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic [DW-1:0] w);
    i_host.wr(OFS_CMD, w);
  endtask
  task automatic rop(input logic [7:0] c, output logic [DW-1:0] d);
    i_host.wr(OFS_CMD, {c, 8'h5a});
    i_host.rd(OFS_CMD, d);
  endtask
  task automatic ev(input int n);
    q.delete();
    @(posedge clk_sys);
    ev_start <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      ev_start  <= 1'b0;
      hit_valid <= 1'b1;
      hit_word  <= 32'h0000_00a0 + i;
    end
    @(posedge clk_sys);
    ev_start  <= 1'b0;
    hit_valid <= 1'b0;
    ev_end    <= 1'b1;
    @(posedge clk_sys);
    ev_end <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic t_defaults();
    rop(OP_DT_RD, v);
    chk(v, {14'h0, DT_RST});
    rop(OP_HT_RD, v);
    chk(v, 16'h0000);
    rop(OP_HL_RD, v);
    chk(v, 16'h0009);
    rop(OP_ET_RD, v);
    chk(v, 16'h0000);
    rop(OP_BS_RD, v);
    chk(v, 16'h0007);
    chk(&chan_en, 1'b1);
    $display("test defaults done");
  endtask
  task automatic t_settings();
    op({OP_BS_SET, 8'h00});
    repeat (2) @(posedge clk_sys);
    i_host.rd(OFS_CMD, v);
    chk(v, 16'h0000);
    i_host.rd(OFS_STATUS, v);
    chk(v, 16'(TDCOH_WAIT_PARAM));
    chk(busy, 1'b1);
    op(16'h0003);
    chk(buf_size_code, 3'h3);
    for (int c = 0; c < 9; c++)
    begin
      op({OP_HL_SET, 8'h00});
      op(16'hfff0 | 16'(c));
      rop(OP_HL_RD, v);
      chk(v, 16'(c));
      if (c < 8)
      begin
        op({OP_BS_SET, 8'h00});
        op(16'(c));
        rop(OP_BS_RD, v);
        chk(v, 16'(c));
      end
    end
    op({OP_ET_SET, 8'h00});
    op(16'hffff);
    rop(OP_ET_RD, v);
    chk(v, 16'h07ff);
    op(16'h30a5);
    rop(OP_HT_RD, v);
    chk(v, 16'h0001);
    op({OP_HT_DIS, 8'h00});
    rop(OP_HT_RD, v);
    chk(v, 16'h0000);
    $display("test settings done");
  endtask
  task automatic t_irq();
    i_host.wr(OFS_IRQ_MASK, 16'h0004);
    op({OP_HL_RD, 8'h00});
    op(16'h3305);
    i_host.rd(OFS_CMD, v);
    chk(v, 16'h0008);
    op(16'hff00);
    i_host.rd(OFS_IRQ_STAT, v);
    chk(v, 16'h0004);
    chk(irq, 1'b1);
    i_host.wr(OFS_IRQ_STAT, 16'h0004);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(irq, 1'b0);
    i_host.rd(4'h2, v);
    chk(v, 16'h0000);
    $display("test interrupts done");
  endtask
  task automatic t_chan();
    @(posedge clk_sys);
    ev_start <= 1'b1;
    @(posedge clk_sys);
    ev_start <= 1'b0;
    op(16'h4105);
    op(16'h417f);
    op(16'h41ff);
    chk($countones(chan_en), 126);
    chk(chan_en[127], 1'b0);
    op(16'h4005);
    chk(chan_en[5], 1'b1);
    // A command offered while the clock enable is low must not land
    ce <= 1'b0;
    op(16'h4105);
    ce <= 1'b1;
    chk(chan_en[5], 1'b1);
    ev(0);
    $display("test channels done");
  endtask
  task automatic t_events();
    op({OP_HT_EN, 8'h00});
    op({OP_HL_SET, 8'h00});
    op(16'h0001);
    ev(2);
    chk(q.size(), 4);
    chk(q[0], 32'h1000_0000);
    chk(q[1], 32'h0000_00a0);
    chk(q[2], 32'h2000_1000);
    chk(q[3][31:28], 4'h3);
    int_err <= 11'h001;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(global_err, 1'b1);
    ev(1);
    chk(q[2], 32'h2000_0800);
    op({OP_EM_DIS, 8'h00});
    ev(1);
    chk(q.size(), 3);
    op({OP_BP_EN, 8'h00});
    ev(1);
    chk(q.size(), 2);
    op({OP_BP_DIS, 8'h00});
    ev(1);
    chk(q.size(), 3);
    int_err    <= '0;
    trig_match <= 1'b0;
    ev(2);
    chk(q.size(), 2);
    i_host.rd(OFS_IRQ_STAT, v);
    chk(v, 16'((1 << IRQ_SIZE) | (1 << IRQ_GERR)));
    $display("test events done");
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    t_defaults();
    t_settings();
    t_irq();
    t_chan();
    t_events();
    wrap_up();
  end
endmodule

// >>> verification/tdcoh_host.sv
// Host model issuing opcodes and parameter words on the register port
`timescale 1ns/1ps
module tdcoh_host
  import tdcoh_pkg::*;
(
  // Register port
  input  wire logic                     clk_sys,
  output logic      [tdcoh_pkg::AW-1:0] reg_addr,
  output logic      [tdcoh_pkg::DW-1:0] reg_wdata,
  output logic                          reg_wr,
  output logic                          reg_rd,
  input  wire logic [tdcoh_pkg::DW-1:0] reg_rdata
);
  initial
  begin
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One-cycle write; released data no longer shows the old word
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask

  // One-cycle read; data taken in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

// >>> verification/tdcoh_top_sva.sv
// Checker of the opcode handler port behaviour
`timescale 1ns/1ps
module tdcoh_top_sva
  import tdcoh_pkg::*;
#(
  parameter int NUM_CH = 128
) (
  // Clock and reset
  input wire logic                         clk_sys,
  input wire logic                         arst_n,
  // Register port
  input wire logic                         ce,
  input wire logic [tdcoh_pkg::AW-1:0]     reg_addr,
  input wire logic [tdcoh_pkg::DW-1:0]     reg_wdata,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [tdcoh_pkg::DW-1:0]     reg_rdata,
  input wire logic                         irq,
  // Settings and stream
  input wire logic                         busy,
  input wire logic [2:0]                   buf_size_code,
  input wire logic [tdcoh_pkg::MAX_CH-1:0] chan_en,
  input wire logic                         ev_start,
  input wire logic                         ev_end,
  input wire logic                         hit_valid,
  input wire logic                         out_valid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire       cw = ce && reg_wr && reg_addr == OFS_CMD;
  wire       cr = ce && reg_rd && reg_addr == OFS_CMD;
  wire [7:0] op = reg_wdata[15:8];

  property p_rd_only;
    reg_rdata != '0 |-> $past(ce && reg_rd);
  endproperty
  a_rd_only: assert property (p_rd_only) else $error("read data outside a read");
  property p_ro_busy;
    cw && !busy && op == OP_HL_RD |=> busy;
  endproperty
  a_ro_busy: assert property (p_ro_busy) else $error("no wait after read opcode");
  property p_ro_word;
    cw && !busy && op == OP_DT_RD ##1 cr |=> reg_rdata == {14'h0000, DT_RST} && !busy;
  endproperty
  a_ro_word: assert property (p_ro_word) else $error("bad dead time word");
  property p_hold;
    busy && !reg_wr && !reg_rd |=> busy;
  endproperty
  a_hold: assert property (p_hold) else $error("wait left without access");
  property p_bs;
    cw && !busy && op == OP_BS_SET ##1 cw |=> !busy && buf_size_code == $past(reg_wdata[2:0]);
  endproperty
  a_bs: assert property (p_bs) else $error("buffer size not taken");
  property p_ch_dis;
    cw && !busy && op == OP_CH_DIS && reg_wdata[7:0] < NUM_CH |=> !chan_en[$past(reg_wdata[6:0])];
  endproperty
  a_ch_dis: assert property (p_ch_dis) else $error("channel not disabled");
  property p_ch_en;
    cw && !busy && op == OP_CH_EN && reg_wdata[7:0] < NUM_CH |=> chan_en[$past(reg_wdata[6:0])];
  endproperty
  a_ch_en: assert property (p_ch_en) else $error("channel not enabled");
  property p_out;
    $rose(out_valid) |-> $past(ev_start || hit_valid) || $past(ev_end, 2);
  endproperty
  a_out: assert property (p_out) else $error("output word without event input");

  c_param: cover property (cw && op == OP_HL_SET ##1 cw);
  c_out: cover property ($rose(out_valid));
  c_irq: cover property (irq);
endmodule

bind tdcoh_top tdcoh_top_sva #(.NUM_CH(NUM_CH)) i_sva (.clk_sys, .arst_n, .ce, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .busy, .buf_size_code, .chan_en, .ev_start,
  .ev_end, .hit_valid, .out_valid);
